/* File: hdl/hdm_pkg.sv */
// constants, types and helpers shared by both mailbox ends
// assumes one clock and a byte-wide host bus on that clock
package hdm_pkg;
   // ==========================================
   // host bus addresses (7-bit byte addresses)
   localparam int HA_W = 7;
   localparam logic [6:0] HA_HCMD = 7'h40;
   localparam logic [6:0] HA_HBUSY = 7'h41;
   localparam logic [6:0] HA_HGEN_LO = 7'h42;
   localparam logic [6:0] HA_HGEN_HI = 7'h43;
   localparam logic [6:0] HA_DCMD = 7'h60;
   localparam logic [6:0] HA_DBUSY = 7'h61;
   localparam logic [6:0] HA_DGEN_LO = 7'h62;
   localparam logic [6:0] HA_DGEN_HI = 7'h63;
   localparam logic [6:0] HA_VEC = 7'h68;
   localparam logic [6:0] HA_DATA_END = 7'h1f;
   // ==========================================
   // dsp data space addresses
   localparam logic [15:0] DA_HCMD = 16'hd140;
   localparam logic [15:0] DA_HBUSY = 16'hd141;
   localparam logic [15:0] DA_HGEN_LO = 16'hd142;
   localparam logic [15:0] DA_HGEN_HI = 16'hd143;
   localparam logic [15:0] DA_HGEN = 16'hd144;
   localparam logic [15:0] DA_DCMD = 16'hd160;
   localparam logic [15:0] DA_DBUSY = 16'hd161;
   localparam logic [15:0] DA_DGEN_LO = 16'hd162;
   localparam logic [15:0] DA_DGEN_HI = 16'hd163;
   localparam logic [15:0] DA_DGEN = 16'hd164;
   localparam logic [15:0] DA_VEC = 16'hd168;
   localparam logic [11:0] DA_DATA_BASE = 12'hd12;
   // ==========================================
   // fields and reset values
   localparam int BUSY_BIT = 15;
   localparam int NDATA = 16;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] BUSY_BYTE = 8'h80;
   // ==========================================
   // host controller: axi offsets and orders
   localparam int AXI_AW = 4;
   localparam logic [3:0] AX_ORDER = 4'h0;
   localparam logic [3:0] AX_STATUS = 4'h4;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h1;
   localparam logic [1:0] OP_INTACK = 2'h2;
   localparam logic [1:0] OP_CMD = 2'h3;
   typedef enum logic [4:0] {
      HS_IDLE = 5'b00001,
      HS_POLL = 5'b00010,
      HS_POLLW = 5'b00100,
      HS_ISSUE = 5'b01000,
      HS_CAPT = 5'b10000
   } hdm_hstate_e;
   // replace one byte lane of a 16-bit word
   function automatic logic [15:0] hdm_put_byte(
      input logic [15:0] w, input logic hi, input logic [7:0] b);
      hdm_put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
   endfunction
endpackage

/* File: hdl/hdm_host_if.sv */
// host parallel bus between the mailbox and its host
// assumes both ends run on ref_clk; strobes are one-cycle pulses
`timescale 1ns/1ps
interface hdm_host_if;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic intack;
   modport device(input addr, input wdata, input wr, input rd,
      input intack, output rdata);
   modport host(output addr, output wdata, output wr, output rd,
      output intack, input rdata);
endinterface

/* File: hdl/hdm_dev_end.sv */
// mailbox device end: host bus on one side, dsp data space on other
// assumes host strobes on ref_clk; read data one cycle after strobe
// Functional notes
// - host command write sets host busy flag
// - dsp write to host busy clears it
// - host writes command only when flag zero; not checked here, a host write at 40h always loads and sets the flag
// - dsp command write sets dsp busy flag
// - host write to dsp busy clears it
// - dsp writes command only when flag zero
// - interrupt acknowledge returns the vector byte
// - host command is 8-bit, at 40h
// - dsp command is 8-bit, host reads 60h
// - host generic word, bytes at 42h/43h
// - dsp generic word, host reads 62h/63h
// - sixteen host data words, byte writes
`timescale 1ns/1ps
module hdm_dev_end (
   input wire logic ref_clk,
   input wire logic rst,
   hdm_host_if.device hbus,
   input wire logic [15:0] dsp_addr,
   input wire logic dsp_wr,
   input wire logic dsp_rd,
   input wire logic [15:0] dsp_wdata,
   output logic [15:0] dsp_rdata,
   output logic dsp_cmd_refused,
   output logic host_box_busy,
   output logic dsp_box_busy
);
   import hdm_pkg::*;

   // ==========================================
   // storage
   logic [7:0] host_command_ff;
   logic [7:0] dsp_command_ff;
   logic host_busy_ff;
   logic dsp_busy_ff;
   logic [15:0] host_gen_ff;
   logic [15:0] dsp_gen_ff;
   logic [7:0] vec_ff;
   logic [15:0] data_ff [NDATA];
   logic [7:0] hrdata_ff;
   logic [15:0] drdata_ff;
   logic refused_ff;

   // ==========================================
   // access decode
   logic h_cmd_wr;
   logic h_dbusy_wr;
   logic h_data_wr;
   logic d_cmd_wr;
   logic d_cmd_ok;
   logic d_hbusy_wr;
   logic d_data_rd;
   logic [3:0] d_idx;

   // host side writes
   assign h_cmd_wr = hbus.wr && (hbus.addr == HA_HCMD);
   assign h_dbusy_wr = hbus.wr && (hbus.addr == HA_DBUSY);
   assign h_data_wr = hbus.wr && (hbus.addr <= HA_DATA_END);
   // dsp side accesses
   assign d_cmd_wr = dsp_wr && (dsp_addr == DA_DCMD);
   // a command while the box is blocked is dropped, not queued
   assign d_cmd_ok = d_cmd_wr && !dsp_busy_ff;
   assign d_hbusy_wr = dsp_wr && (dsp_addr == DA_HBUSY);
   assign d_data_rd = dsp_addr[15:4] == DA_DATA_BASE;
   assign d_idx = dsp_addr[3:0];

   // ==========================================
   // busy flags
   // host box: set on command, cleared only by dsp write to it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         host_busy_ff <= 1'b0;
      end else if (h_cmd_wr) begin
         host_busy_ff <= 1'b1;
      end else if (d_hbusy_wr) begin
         host_busy_ff <= 1'b0;
      end
   end

   // dsp box: set on dsp command, cleared by host write to it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dsp_busy_ff <= 1'b0;
      end else if (d_cmd_ok) begin
         dsp_busy_ff <= 1'b1;
      end else if (h_dbusy_wr) begin
         dsp_busy_ff <= 1'b0;
      end
   end

   // ==========================================
   // command registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         host_command_ff <= CMD_RST;
      end else if (h_cmd_wr) begin
         host_command_ff <= hbus.wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dsp_command_ff <= CMD_RST;
      end else if (d_cmd_ok) begin
         dsp_command_ff <= dsp_wdata[7:0];
      end
   end

   // one-cycle flag telling the dsp its command was dropped
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         refused_ff <= 1'b0;
      end else begin
         refused_ff <= d_cmd_wr && dsp_busy_ff;
      end
   end

   // ==========================================
   // data words, kept through reset on purpose
   // host generic word, written a byte at a time
   always_ff @(posedge ref_clk) begin
      if (hbus.wr && (hbus.addr == HA_HGEN_LO)) begin
         host_gen_ff <= hdm_put_byte(host_gen_ff, 1'b0,
            hbus.wdata);
      end else if (hbus.wr && (hbus.addr == HA_HGEN_HI)) begin
         host_gen_ff <= hdm_put_byte(host_gen_ff, 1'b1,
            hbus.wdata);
      end
   end

   // dsp generic word: word or byte writes from the dsp
   always_ff @(posedge ref_clk) begin
      if (dsp_wr && (dsp_addr == DA_DGEN)) begin
         dsp_gen_ff <= dsp_wdata;
      end else if (dsp_wr && (dsp_addr == DA_DGEN_LO)) begin
         dsp_gen_ff <= hdm_put_byte(dsp_gen_ff, 1'b0,
            dsp_wdata[7:0]);
      end else if (dsp_wr && (dsp_addr == DA_DGEN_HI)) begin
         dsp_gen_ff <= hdm_put_byte(dsp_gen_ff, 1'b1,
            dsp_wdata[7:0]);
      end
   end

   // vector: written by the dsp only, host cannot touch it
   always_ff @(posedge ref_clk) begin
      if (dsp_wr && (dsp_addr == DA_VEC)) begin
         vec_ff <= dsp_wdata[7:0];
      end
   end

   // host data words, byte lane picked by address bit 0
   always_ff @(posedge ref_clk) begin
      if (h_data_wr) begin
         data_ff[hbus.addr[4:1]] <= hdm_put_byte(
            data_ff[hbus.addr[4:1]], hbus.addr[0],
            hbus.wdata);
      end
   end

   // ==========================================
   // host read port, registered
   // acknowledge outranks a plain read in the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         hrdata_ff <= 8'h00;
      end else if (hbus.intack) begin
         hrdata_ff <= vec_ff;
      end else if (hbus.rd) begin
         unique case (hbus.addr)
            HA_HBUSY: hrdata_ff <= host_busy_ff ?
               BUSY_BYTE : 8'h00;
            HA_DCMD: hrdata_ff <= dsp_command_ff;
            HA_DBUSY: hrdata_ff <= dsp_busy_ff ?
               BUSY_BYTE : 8'h00;
            HA_DGEN_LO: hrdata_ff <= dsp_gen_ff[7:0];
            HA_DGEN_HI: hrdata_ff <= dsp_gen_ff[15:8];
            HA_VEC: hrdata_ff <= vec_ff;
            default: hrdata_ff <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // dsp read port, registered
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         drdata_ff <= 16'h0000;
      end else if (dsp_rd && d_data_rd) begin
         drdata_ff <= data_ff[d_idx];
      end else if (dsp_rd) begin
         unique case (dsp_addr)
            DA_HCMD: drdata_ff <= {8'h00, host_command_ff};
            DA_HGEN_LO: drdata_ff <= {8'h00, host_gen_ff[7:0]};
            DA_HGEN_HI: drdata_ff <= {8'h00, host_gen_ff[15:8]};
            DA_HGEN: drdata_ff <= host_gen_ff;
            DA_DBUSY: drdata_ff <= {dsp_busy_ff,
               15'h0000};
            DA_VEC: drdata_ff <= {8'h00, vec_ff};
            default: drdata_ff <= 16'h0000;
         endcase
      end
   end

   // ==========================================
   // outputs
   assign hbus.rdata = hrdata_ff;
   assign dsp_rdata = drdata_ff;
   assign dsp_cmd_refused = refused_ff;
   assign host_box_busy = host_busy_ff;
   assign dsp_box_busy = dsp_busy_ff;
endmodule

/* File: hdl/hdm_host_end.sv */
// host end: takes bus orders over axi4-lite, runs host bus cycles
// assumes the device answers a read one cycle after the strobe
`timescale 1ns/1ps
module hdm_host_end (
   input wire logic ref_clk,
   input wire logic rst,
   hdm_host_if.host hbus,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import hdm_pkg::*;

   // ==========================================
   // axi write channel
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic wr_exec;
   logic order_take;
   logic status_wr;

   // both halves held, response not yet out: act once
   assign wr_exec = !awready_ff && !wready_ff && !bvalid_ff;
   assign order_take = wr_exec && (awaddr_ff == AX_ORDER);
   assign status_wr = wr_exec && (awaddr_ff == AX_STATUS);

   // address and data may arrive in either order
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OK;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            wdata_ff <= s_axi_wdata;
         end
         if (wr_exec) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (awaddr_ff == AX_ORDER ||
               awaddr_ff == AX_STATUS) ? RESP_OK : RESP_ERR;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // ==========================================
   // bus sequencer
   hdm_hstate_e state_ff;
   hdm_hstate_e nxt_state;
   logic [1:0] op_ff;
   logic [6:0] addr_ff;
   logic [7:0] data_ff;
   logic [7:0] rd_ff;
   logic refused_ff;
   logic nxt_refused;
   logic wr_ff;
   logic rdstb_ff;
   logic intack_ff;
   logic [6:0] baddr_ff;

   // next state; guarded command polls the busy byte first
   always_comb begin
      nxt_state = state_ff;
      nxt_refused = 1'b0;
      unique case (state_ff)
         HS_IDLE: begin
            if (order_take) begin
               nxt_state = (wdata_ff[17:16] == OP_CMD) ?
                  HS_POLL : HS_ISSUE;
            end
         end
         HS_POLL: nxt_state = HS_POLLW;
         HS_POLLW: begin
            // blocked box: the command is not written
            if (hbus.rdata[BUSY_BIT - 8]) begin
               nxt_state = HS_IDLE;
               nxt_refused = 1'b1;
            end else begin
               nxt_state = HS_ISSUE;
            end
         end
         HS_ISSUE: nxt_state = HS_CAPT;
         HS_CAPT: nxt_state = HS_IDLE;
      endcase
      if (order_take && state_ff != HS_IDLE) begin
         nxt_refused = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= HS_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // order fields latched when the order is taken
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         op_ff <= OP_WRITE;
         addr_ff <= 7'h00;
         data_ff <= 8'h00;
      end else if (order_take && state_ff == HS_IDLE) begin
         op_ff <= wdata_ff[17:16];
         addr_ff <= wdata_ff[14:8];
         data_ff <= wdata_ff[7:0];
      end
   end

   // bus strobes, one cycle each, from flops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ff <= 1'b0;
         rdstb_ff <= 1'b0;
         intack_ff <= 1'b0;
         baddr_ff <= 7'h00;
      end else begin
         wr_ff <= 1'b0;
         rdstb_ff <= 1'b0;
         intack_ff <= 1'b0;
         if (nxt_state == HS_POLL) begin
            rdstb_ff <= 1'b1;
            baddr_ff <= HA_HBUSY;
         end else if (nxt_state == HS_ISSUE) begin
            baddr_ff <= (state_ff == HS_POLLW) ? HA_HCMD :
               wdata_ff[14:8];
            wr_ff <= (state_ff == HS_POLLW) ||
               (wdata_ff[17:16] == OP_WRITE);
            rdstb_ff <= (state_ff == HS_IDLE) &&
               (wdata_ff[17:16] == OP_READ);
            intack_ff <= (state_ff == HS_IDLE) &&
               (wdata_ff[17:16] == OP_INTACK);
         end
      end
   end

   // answer byte captured; refusal sticky, set beats clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_ff <= 8'h00;
         refused_ff <= 1'b0;
      end else begin
         if (state_ff == HS_CAPT && op_ff != OP_WRITE &&
            op_ff != OP_CMD) begin
            rd_ff <= hbus.rdata;
         end
         if (nxt_refused) begin
            refused_ff <= 1'b1;
         end else if (status_wr && wdata_ff[1]) begin
            refused_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // axi read channel
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= RESP_OK;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rresp_ff <= RESP_OK;
         if (s_axi_araddr == AX_ORDER) begin
            rdata_ff <= {14'h0000, op_ff, 1'b0, addr_ff, data_ff};
         end else if (s_axi_araddr == AX_STATUS) begin
            rdata_ff <= {16'h0000, rd_ff, 6'h00, refused_ff,
               state_ff != HS_IDLE};
         end else begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_ERR;
         end
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ==========================================
   // outputs
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign hbus.addr = baddr_ff;
   assign hbus.wdata = data_ff;
   assign hbus.wr = wr_ff;
   assign hbus.rd = rdstb_ff;
   assign hbus.intack = intack_ff;
endmodule

/* File: verif/hdm_properties.sv */
// concurrent checks on the host bus and both busy flags
// assumes the bench instantiates it beside the joining interface
`timescale 1ns/1ps
module hdm_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic intack,
   input wire logic [15:0] dsp_addr,
   input wire logic dsp_wr,
   input wire logic dsp_cmd_refused,
   input wire logic host_box_busy,
   input wire logic dsp_box_busy
);
   import hdm_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ======
   // steps of the two mailboxes
   sequence s_hcmd;
      wr && addr == HA_HCMD;
   endsequence
   sequence s_dcmd;
      dsp_wr && dsp_addr == DA_DCMD;
   endsequence
   sequence s_hclr;
      dsp_wr && dsp_addr == DA_HBUSY;
   endsequence
   sequence s_dclr;
      wr && addr == HA_DBUSY;
   endsequence
   // ======
   // set wins over a clear in the same cycle
   a_hcmd_sets: assert property (s_hcmd |=> host_box_busy)
      else $error("host busy not set by command");
   a_hbusy_clear: assert property (s_hclr ##0 !(wr && addr == HA_HCMD)
      |=> !host_box_busy)
      else $error("host busy not cleared by dsp write");
   a_hbusy_holds: assert property (host_box_busy &&
      !(dsp_wr && dsp_addr == DA_HBUSY) |=> host_box_busy)
      else $error("host busy dropped without dsp write");
   a_dcmd_sets: assert property (s_dcmd |=> dsp_box_busy)
      else $error("dsp busy not set by command");
   a_dbusy_clear: assert property (s_dclr ##0 !(dsp_wr &&
      dsp_addr == DA_DCMD) |=> !dsp_box_busy)
      else $error("dsp busy not cleared by host write");
   a_hbusy_byte: assert property (rd && !intack &&
      addr == HA_HBUSY |=> rdata == ($past(host_box_busy) ?
      BUSY_BYTE : 8'h00))
      else $error("host busy byte wrong");
   a_dbusy_byte: assert property (rd && !intack &&
      addr == HA_DBUSY |=> rdata == ($past(dsp_box_busy) ?
      BUSY_BYTE : 8'h00))
      else $error("dsp busy byte wrong");
   a_cmd_guarded: assert property (s_hcmd |-> !host_box_busy)
      else $error("host command written while busy");
   a_dcmd_refused: assert property (s_dcmd ##0 dsp_box_busy |=>
      dsp_cmd_refused)
      else $error("busy dsp command not refused");
endmodule

/* File: verif/host_dsp_mailbox_bench.sv */
// bench: host end and device end joined by the host bus
// assumes the controller order and status layout of the hand-over
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module host_dsp_mailbox_bench;
   import hdm_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [15:0] dsp_addr = 16'h0, dsp_wdata = 16'h0, dsp_rdata, o;
   logic dsp_wr = 1'b0, dsp_rd = 1'b0, dsp_rd_q = 1'b0;
   logic dsp_cmd_refused, host_box_busy, dsp_box_busy, refd = 1'b0;
   logic [7:0] c, k, v, b;
   logic [15:0] md [16];
   logic [63:0] q [$];
   logic [31:0] seed = 32'h000116f9;
   int fail_count = 0;
   int n_checks = 0;
   hdm_host_if hb ();
   hdm_dev_end i_hdm_dev_end (.ref_clk(ref_clk), .rst(rst), .hbus(hb),
      .dsp_addr(dsp_addr), .dsp_wr(dsp_wr), .dsp_rd(dsp_rd),
      .dsp_wdata(dsp_wdata), .dsp_rdata(dsp_rdata),
      .dsp_cmd_refused(dsp_cmd_refused), .host_box_busy(host_box_busy),
      .dsp_box_busy(dsp_box_busy));
   hdm_host_end i_hdm_host_end (.ref_clk(ref_clk), .rst(rst), .hbus(hb),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   hdm_properties i_hdm_properties (.ref_clk(ref_clk), .rst(rst),
      .addr(hb.addr), .wdata(hb.wdata), .rdata(hb.rdata), .wr(hb.wr),
      .rd(hb.rd), .intack(hb.intack), .dsp_addr(dsp_addr), .dsp_wr(dsp_wr),
      .dsp_cmd_refused(dsp_cmd_refused), .host_box_busy(host_box_busy),
      .dsp_box_busy(dsp_box_busy));
   // ======
   // clock, random source, closing
   initial forever #5 ref_clk = ~ref_clk;
   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task test_done();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tdone(input string nm);
      $display("test %s done", nm);
   endtask
   // ======
   // bus tasks; polls run with no note queued
   task axi_wr(input logic [3:0] a, input logic [31:0] x,
      output logic [1:0] rs);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= x;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // test after the body: the raised valids only land after this step
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            bready <= 1'b0;
            rs = bresp;
         end
      end while (awvalid || wvalid || bready);
   endtask
   task axi_rd(input logic [3:0] a, output logic [31:0] x,
      output logic [1:0] rs);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            rready <= 1'b0;
            x = rdata;
            rs = rresp;
         end
      end while (arvalid || rready);
   endtask
   task host_op(input logic [1:0] op, input logic [6:0] a,
      input logic [7:0] x);
      logic [31:0] s;
      axi_wr(AX_ORDER, {14'h0, op, 1'b0, a, x}, r);
      s = 32'h1;
      while (s[0]) axi_rd(AX_STATUS, s, r);
   endtask
   task status_chk(input logic [7:0] e);
      q.push_back({32'h0000ff03, 16'h0, e, 6'h0, refd, 1'b0});
      axi_rd(AX_STATUS, d, r);
   endtask
   task host_rd(input logic [6:0] a, input logic [7:0] e);
      host_op(OP_READ, a, 8'h00);
      status_chk(e);
   endtask
   task dsp_w(input logic [15:0] a, input logic [15:0] x);
      @(posedge ref_clk);
      dsp_addr <= a;
      dsp_wdata <= x;
      dsp_wr <= 1'b1;
      @(posedge ref_clk);
      dsp_wr <= 1'b0;
   endtask
   task dsp_r(input logic [15:0] a, input logic [15:0] m,
      input logic [15:0] e);
      q.push_back({16'h0, m, 16'h0, e});
      @(posedge ref_clk);
      dsp_addr <= a;
      dsp_rd <= 1'b1;
      @(posedge ref_clk);
      dsp_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   // oldest note against whichever result shows up
   task check_top(input logic [31:0] g, input string nm);
      logic [63:0] n;
      if (q.size() == 0) return;
      n = q.pop_front();
      `CHK(nm, n[31:0], g & n[63:32])
   endtask
   always @(posedge ref_clk) begin
      dsp_rd_q <= dsp_rd;
      if (rvalid && rready) check_top(rdata, "status");
      if (dsp_rd_q) check_top({16'h0, dsp_rdata}, "dsp_rdata");
   end
   // hang guard, far beyond the seven hundred or so cycles needed
   initial begin
      repeat (60000) @(posedge ref_clk);
      fail_count++;
      $display("timeout");
      test_done();
   end
   // ======
   // scenarios
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      host_rd(HA_HBUSY, 8'h00);
      host_rd(HA_DBUSY, 8'h00);
      host_rd(HA_DCMD, CMD_RST);
      dsp_r(DA_HCMD, 16'h00ff, {8'h0, CMD_RST});
      dsp_r(DA_DBUSY, 16'hffff, 16'h0);
      axi_wr(4'h8, 32'h0, r);
      `CHK("bresp", RESP_ERR, r)
      axi_rd(4'hc, d, r);
      `CHK("rresp", RESP_ERR, r)
      `CHK("rdata", 32'h0, d)
      tdone("reset");
      c = rnd();
      host_op(OP_CMD, HA_HCMD, c);
      dsp_r(DA_HCMD, 16'h00ff, {8'h0, c});
      host_rd(HA_HBUSY, BUSY_BYTE);
      host_op(OP_CMD, HA_HCMD, ~c);
      refd = 1'b1;
      host_rd(HA_HBUSY, BUSY_BYTE);
      dsp_r(DA_HCMD, 16'h00ff, {8'h0, c});
      dsp_w(DA_HCMD, 16'h0);
      dsp_r(DA_HBUSY, 16'h0, 16'h0);
      host_rd(HA_HBUSY, BUSY_BYTE);
      dsp_w(DA_HBUSY, {rnd(), rnd()});
      axi_wr(AX_STATUS, 32'h2, r);
      refd = 1'b0;
      host_rd(HA_HBUSY, 8'h00);
      tdone("host command");
      k = rnd();
      dsp_w(DA_DCMD, {8'h0, k});
      host_rd(HA_DCMD, k);
      host_rd(HA_DBUSY, BUSY_BYTE);
      dsp_w(DA_DCMD, {8'h0, ~k});
      host_rd(HA_DCMD, k);
      host_op(OP_WRITE, HA_DBUSY, rnd());
      host_rd(HA_DBUSY, 8'h00);
      dsp_r(DA_DBUSY, 16'hffff, 16'h0);
      tdone("dsp command");
      c = rnd();
      b = rnd();
      host_op(OP_WRITE, HA_HGEN_LO, c);
      host_op(OP_WRITE, HA_HGEN_HI, b);
      dsp_r(DA_HGEN, 16'hffff, {b, c});
      dsp_r(DA_HGEN_HI, 16'h00ff, {8'h0, b});
      for (int n = 0; n < NDATA; n++) begin
         md[n] = {rnd(), rnd()};
         host_op(OP_WRITE, 7'(2 * n), md[n][7:0]);
         host_op(OP_WRITE, 7'(2 * n + 1), md[n][15:8]);
      end
      o = {rnd(), rnd()};
      b = rnd();
      v = rnd();
      dsp_w(DA_DGEN, o);
      dsp_w(DA_DGEN_HI, {8'h0, b});
      dsp_w(DA_VEC, {8'h0, v});
      // second reset must leave all data words alone
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      for (int n = 0; n < NDATA; n++) begin
         dsp_r({DA_DATA_BASE, 4'(n)}, 16'hffff, md[n]);
      end
      host_rd(HA_DGEN_LO, o[7:0]);
      host_rd(HA_DGEN_HI, b);
      tdone("data words");
      host_op(OP_INTACK, 7'h00, 8'h00);
      status_chk(v);
      host_op(OP_WRITE, HA_VEC, ~v);
      host_rd(HA_VEC, v);
      tdone("vector");
      test_done();
   end
endmodule
